// file: core/uhirq_status.sv
// top of the interrupt source status block: flags, enables, wake timer and register port
// assumes event inputs are one-cycle pulses from logic on core_clk, except the clock level
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`include "uhirq_map.svh"
module uhirq_status #(
  parameter int TICK_CYCLES = `UHIRQ_TICK_CYCLES
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // transfer list completion pulses (single or mask combination)
  input  wire logic        iso_list_done,
  input  wire logic        async_list_done,
  input  wire logic        periodic_list_done,
  // power and clocking
  input  wire logic        clocks_running,
  input  wire logic        suspend_enter,
  input  wire logic        host_suspended,
  // dma and frame pulses
  input  wire logic        dma_done,
  input  wire logic        frame_start,
  // outputs
  output logic             irq_req,
  output logic             wake_active
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_a;
  logic rst_n;

  // release is synchronous so no flag sees a partial reset edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_a <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_n <= rst_a;
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  uhirq_pkg::uhirq_flags_t flags;
  uhirq_pkg::uhirq_flags_t enables;
  uhirq_pkg::uhirq_wake_t  wake_ticks;
  logic                    master_irq_enable;
  logic                    clk_stable_pulse;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire sel_mode   = (reg_addr == `UHIRQ_MODE_OFS);
  wire sel_status = (reg_addr == `UHIRQ_STATUS_OFS);
  wire sel_enable = (reg_addr == `UHIRQ_ENABLE_OFS);
  wire sel_pwrdn  = (reg_addr == `UHIRQ_PWRDN_OFS);
  wire wr_status  = reg_wr && sel_status;
  wire wr_enable  = reg_wr && sel_enable;
  wire wr_mode    = reg_wr && sel_mode;
  wire wr_pwrdn   = reg_wr && sel_pwrdn;
  wire bus_access = reg_wr || reg_rd;
  // a zero wake time on an access in suspend closes a running window
  wire wake_cancel = bus_access && host_suspended && (wake_ticks == 16'h0000);

  // ---------------------------------------------------------------
  // event vector
  // ---------------------------------------------------------------
  uhirq_pkg::uhirq_flags_t set_vec;
  uhirq_pkg::uhirq_flags_t clr_vec;
  uhirq_pkg::uhirq_flags_t next_flags;

  assign set_vec[`UHIRQ_ISO_BIT]    = iso_list_done;
  assign set_vec[`UHIRQ_ASYNC_BIT]  = async_list_done;
  assign set_vec[`UHIRQ_PERIOD_BIT] = periodic_list_done;
  assign set_vec[`UHIRQ_CLKST_BIT]  = clk_stable_pulse;
  assign set_vec[`UHIRQ_SUSP_BIT]   = suspend_enter;
  assign set_vec[4]                 = 1'b0;
  assign set_vec[`UHIRQ_DMA_BIT]    = dma_done;
  assign set_vec[2:1]               = 2'h0;
  assign set_vec[`UHIRQ_SOF_BIT]    = frame_start;

  // write one clears, zero keeps; reserved lanes ignored
  assign clr_vec = wr_status ? (reg_wdata[9:0] & `UHIRQ_FLAG_MASK) : `UHIRQ_FLAG_RESET;

  // set does not look at the master enable and wins over a clear
  assign next_flags = ((flags & ~clr_vec) | set_vec) & `UHIRQ_FLAG_MASK;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // status flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) flags <= `UHIRQ_FLAG_RESET;
    else        flags <= next_flags;
  end

  // per-source enables, reserved bits held at zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)         enables <= `UHIRQ_FLAG_RESET;
    else if (wr_enable) enables <= reg_wdata[9:0] & `UHIRQ_FLAG_MASK;
  end

  // master enable and wake time
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_irq_enable <= 1'b0;
      wake_ticks        <= `UHIRQ_WAKE_RESET;
    end else begin
      if (wr_mode)  master_irq_enable <= reg_wdata[`UHIRQ_MASTER_BIT];
      if (wr_pwrdn) wake_ticks        <= reg_wdata[`UHIRQ_WAKE_MSB:`UHIRQ_WAKE_LSB];
    end
  end

  // ---------------------------------------------------------------
  // interrupt request
  // ---------------------------------------------------------------
  // enabled flag and master enable
  wire irq_cause = master_irq_enable && (|(flags & enables));

  // registered so the pin never glitches on a bus cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) irq_req <= 1'b0;
    else        irq_req <= irq_cause;
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // reserved and unmapped read as zero
  wire [31:0] rd_status = {22'h000000, flags};
  wire [31:0] rd_enable = {22'h000000, enables};
  wire [31:0] rd_mode   = {31'h00000000, master_irq_enable};
  wire [31:0] rd_pwrdn  = {wake_ticks, 16'h0000};
  wire [31:0] rd_mux    = sel_status ? rd_status :
                          sel_enable ? rd_enable :
                          sel_mode   ? rd_mode   :
                          sel_pwrdn  ? rd_pwrdn  : 32'h00000000;

  // data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)      reg_rdata <= 32'h00000000;
    else if (reg_rd) reg_rdata <= rd_mux;
    else             reg_rdata <= 32'h00000000;
  end

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  uhirq_clk_watch u_clk_watch (
    .core_clk         (core_clk),
    .rst_n            (rst_n),
    .clocks_running   (clocks_running),
    .clk_stable_pulse (clk_stable_pulse)
  );

  // any access while suspended with a nonzero wake time opens the wake window
  uhirq_wake_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_wake_timer (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .trigger     (bus_access && host_suspended),
    .wake_ticks  (wake_ticks),
    .wake_active (wake_active)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  w1c_clear_a: assert property (
    (wr_status && set_vec == 10'h000) |=> ((flags & $past(reg_wdata[9:0])) == 10'h000))
    else $error("written one did not clear its flag");

  zero_keeps_a: assert property (
    wr_status |=> (($past(flags) & ~$past(reg_wdata[9:0]) & ~flags) == 10'h000))
    else $error("flag lost on a zero write");

  set_no_master_a: assert property (
    (frame_start && !master_irq_enable) |=> flags[`UHIRQ_SOF_BIT])
    else $error("frame flag not latched with master enable off");

  iso_set_a: assert property (
    iso_list_done |=> flags[`UHIRQ_ISO_BIT])
    else $error("isochronous flag not set");

  async_set_a: assert property (
    async_list_done |=> flags[`UHIRQ_ASYNC_BIT])
    else $error("asynchronous flag not set");

  periodic_set_a: assert property (
    periodic_list_done |=> flags[`UHIRQ_PERIOD_BIT])
    else $error("periodic flag not set");

  clk_stable_set_a: assert property (
    $rose(u_clk_watch.sync_b) |-> ##2 flags[`UHIRQ_CLKST_BIT])
    else $error("clock-stable flag not set two cycles after rise");

  suspend_set_a: assert property (
    suspend_enter |=> flags[`UHIRQ_SUSP_BIT])
    else $error("suspend flag not set");

  wake_open_a: assert property (
    (bus_access && host_suspended && wake_ticks != 16'h0000) |=> wake_active ##1 (wake_active || $past(wake_cancel)))
    else $error("access in suspend did not wake");

  dma_quiet_a: assert property (
    (!flags[`UHIRQ_DMA_BIT] && !dma_done) |=> !flags[`UHIRQ_DMA_BIT])
    else $error("dma flag set without completion");

  sof_quiet_a: assert property (
    (!flags[`UHIRQ_SOF_BIT] && !frame_start) |=> !flags[`UHIRQ_SOF_BIT])
    else $error("frame flag set without event");

  reserved_zero_a: assert property (
    reg_rd && sel_status |=> (reg_rdata[31:10] == 22'h000000 && reg_rdata[4] == 1'b0 && reg_rdata[2:1] == 2'h0))
    else $error("reserved status bits read nonzero");

  status_read_a: assert property (
    (reg_rd && sel_status) |=> (reg_rdata[9:0] == $past(flags)))
    else $error("status read returned wrong flags");

  irq_gate_a: assert property (
    (!master_irq_enable || (flags & enables) == 10'h000) |=> !irq_req)
    else $error("request raised without enabled flag");

  irq_raise_a: assert property (
    irq_cause |=> irq_req)
    else $error("request not raised for enabled flag");

  clear_then_drop_c: cover property (
    irq_req && wr_status ##1 !irq_cause ##1 !irq_req);

  set_beats_clear_c: cover property (
    wr_status && frame_start && reg_wdata[`UHIRQ_SOF_BIT] ##1 flags[`UHIRQ_SOF_BIT]);

  wake_window_c: cover property (
    host_suspended && bus_access ##1 wake_active ##[1:1000] !wake_active);

  clk_event_c: cover property (
    clk_stable_pulse ##1 flags[`UHIRQ_CLKST_BIT]);

endmodule : uhirq_status

// file: core/uhirq_map.svh
// constants of the usb host interrupt source status block
// assumes a 32-bit register port with byte offsets and a 40 MHz core clock
`ifndef UHIRQ_MAP_SVH
`define UHIRQ_MAP_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define UHIRQ_MODE_OFS     16'h0300
`define UHIRQ_STATUS_OFS   16'h0310
`define UHIRQ_ENABLE_OFS   16'h0314
`define UHIRQ_PWRDN_OFS    16'h0354

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define UHIRQ_ISO_BIT      9
`define UHIRQ_ASYNC_BIT    8
`define UHIRQ_PERIOD_BIT   7
`define UHIRQ_CLKST_BIT    6
`define UHIRQ_SUSP_BIT     5
`define UHIRQ_DMA_BIT      3
`define UHIRQ_SOF_BIT      0
`define UHIRQ_MASTER_BIT   0
`define UHIRQ_WAKE_LSB     16
`define UHIRQ_WAKE_MSB     31
`define UHIRQ_FLAG_MASK    10'h3e9
`define UHIRQ_FLAG_RESET   10'h000
`define UHIRQ_WAKE_RESET   16'h000a

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define UHIRQ_CLK_PERIOD_NS 25
`define UHIRQ_WAKE_TICK_NS  1000
`define UHIRQ_TICK_CYCLES   ((`UHIRQ_WAKE_TICK_NS + `UHIRQ_CLK_PERIOD_NS - 1) / `UHIRQ_CLK_PERIOD_NS)

`endif

// file: core/uhirq_pkg.sv
// types shared by the interrupt source status block
// assumes the constants header is compiled alongside
package uhirq_pkg;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef logic [9:0]  uhirq_flags_t;
  typedef logic [15:0] uhirq_wake_t;

  typedef enum logic [0:0] {
    WAKE_IDLE = 1'b0,
    WAKE_RUN  = 1'b1
  } uhirq_wake_state_t;

endpackage : uhirq_pkg

// file: core/uhirq_clk_watch.sv
// clock-stable detector: synchronises the clocks-running level and pulses on its rise
// assumes the level comes from the clock generator outside this domain
`timescale 1ns/100ps
module uhirq_clk_watch (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // clock generator level
  input  wire logic clocks_running,
  // event to the status logic
  output logic      clk_stable_pulse
);

  logic sync_a;
  logic sync_b;
  logic seen;

  // reset value low so that power-on with clocks up gives one event
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      seen   <= 1'b0;
    end else begin
      sync_a <= clocks_running;
      sync_b <= sync_a;
      seen   <= sync_b;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_stable_pulse <= 1'b0;
    end else begin
      clk_stable_pulse <= sync_b & ~seen;
    end
  end

  stable_single_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_stable_pulse |=> !clk_stable_pulse)
    else $error("clock-stable event longer than one cycle");

endmodule : uhirq_clk_watch

// file: core/uhirq_wake_timer.sv
// wake window timer: holds the core awake for a number of microsecond ticks
// assumes the trigger is already qualified by the suspended state
`timescale 1ns/100ps
`include "uhirq_map.svh"
module uhirq_wake_timer #(
  parameter int TICK_CYCLES = `UHIRQ_TICK_CYCLES
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // control
  input  wire logic                 trigger,
  input  wire uhirq_pkg::uhirq_wake_t wake_ticks,
  // status
  output logic                      wake_active
);

  localparam int DW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(TICK_CYCLES - 1);

  uhirq_pkg::uhirq_wake_state_t state;
  uhirq_pkg::uhirq_wake_state_t next_state;
  uhirq_pkg::uhirq_wake_t       count;
  logic [DW-1:0]                div;
  wire                          tick = (div == DIV_LAST);
  wire                          last = tick && (count == 16'h0001);

  // reload on each access, zero time means no wake
  always_comb begin
    next_state = state;
    unique case (state)
      uhirq_pkg::WAKE_IDLE: if (trigger && wake_ticks != 16'h0000) next_state = uhirq_pkg::WAKE_RUN;
      uhirq_pkg::WAKE_RUN: begin
        if (trigger) next_state = (wake_ticks != 16'h0000) ? uhirq_pkg::WAKE_RUN : uhirq_pkg::WAKE_IDLE;
        else if (last) next_state = uhirq_pkg::WAKE_IDLE;
      end
    endcase
  end

  // tick divider restarts with each reload so the window is never short
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= uhirq_pkg::WAKE_IDLE;
      count <= 16'h0000;
      div   <= '0;
    end else begin
      state <= next_state;
      if (trigger) begin
        count <= wake_ticks;
        div   <= '0;
      end else if (state == uhirq_pkg::WAKE_RUN) begin
        div <= tick ? '0 : div + DW'(1);
        if (tick) count <= count - 16'h0001;
      end
    end
  end

  assign wake_active = (state == uhirq_pkg::WAKE_RUN);

  wake_ends_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (last && !trigger) |=> !wake_active)
    else $error("wake window did not close after last tick");

endmodule : uhirq_wake_timer

// file: verification/uhirq_host_model.sv
// host processor model driving the register port of the status block
// assumes one clock; every strobe launches right after a rising edge
`timescale 1ns/100ps
module uhirq_host_model (
  // clock
  input  wire logic        core_clk,
  // register port
  output logic      [15:0] reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd
);
  // idle bus from time zero
  initial begin
    reg_addr  = 16'h0000;
    reg_wdata = 32'h00000000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // reserved kept zero
  // callers hand in data with reserved positions cleared
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d; // stale data must not look valid
  endtask : wr

  // idle gap first so request lag has settled; returns mid data cycle
  task automatic rd(input logic [15:0] a);
    repeat (3) @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(negedge core_clk);
  endtask : rd
endmodule : uhirq_host_model

// file: verification/tb_usb_host_irq_status.sv
// self-checking bench for the interrupt source status block
// assumes the host model owns the register port; events are driven here
`timescale 1ns/100ps
`include "uhirq_map.svh"
module tb_usb_host_irq_status;
  localparam int TICKS = 2;
  logic        core_clk, arst_n, clocks_running, host_suspended;
  logic        reg_wr, reg_rd, irq_req, wake_active, rd_q, mst;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, w;
  logic [5:0]  ev, m;
  logic [9:0]  flg, en;
  logic [32:0] expq[$];
  logic [32:0] e;
  int          fails, comparisons, seed, pos[6];

  // ---------------------------------------------------------------
  // instances
  // ---------------------------------------------------------------
  uhirq_host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                         .reg_wr(reg_wr), .reg_rd(reg_rd));
  uhirq_status #(.TICK_CYCLES(TICKS)) DUT (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .iso_list_done(ev[0]),
    .async_list_done(ev[1]), .periodic_list_done(ev[2]), .clocks_running(clocks_running),
    .suspend_enter(ev[3]), .host_suspended(host_suspended), .dma_done(ev[4]),
    .frame_start(ev[5]), .irq_req(irq_req), .wake_active(wake_active));

  // ---------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------
  task automatic cmp_word(input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %0t read data %h expected %h", $time, g, x);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic x, input logic g);
    comparisons++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %0t output bit %b expected %b", $time, g, x);
    end
  endtask : cmp_bit

  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  // read data stands only in the cycle after the strobe
  always @(posedge core_clk) rd_q <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_q === 1'b1) begin
      e = expq.pop_front();
      cmp_word(e[31:0], reg_rdata);
      cmp_bit(e[32], irq_req);
    end
  end

  // ---------------------------------------------------------------
  // stimulus helpers
  // ---------------------------------------------------------------
  // note expected word and request level, then issue the read
  task automatic rdx(input logic [15:0] a, input logic [31:0] d);
    expq.push_back({mst & (|(flg & en)), d});
    host.rd(a);
  endtask : rdx

  task automatic pulse(input logic [5:0] x);
    @(posedge core_clk);
    ev <= x;
    @(posedge core_clk);
    ev <= 6'h00;
    for (int i = 0; i < 6; i++) if (x[i]) flg[pos[i]] = 1'b1;
  endtask : pulse

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    #(5000 * 25);
    fails++;
    summarize();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 14;
    pos = '{9, 8, 7, 5, 3, 0};
    {arst_n, clocks_running, host_suspended, mst} = 4'h0;
    {ev, flg, en} = '0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    rdx(`UHIRQ_STATUS_OFS, 32'h0);
    rdx(`UHIRQ_ENABLE_OFS, 32'h0);
    rdx(`UHIRQ_MODE_OFS, 32'h0);
    rdx(`UHIRQ_PWRDN_OFS, 32'h000a0000);
    rdx(16'h0400, 32'h0);
    // each of the six pulsed sources alone: set, keep on zero write, clear on one
    for (int i = 0; i < 6; i++) begin
      pulse(6'h01 << i);
      rdx(`UHIRQ_STATUS_OFS, {22'h0, flg});
      host.wr(`UHIRQ_STATUS_OFS, 32'h0);
      rdx(`UHIRQ_STATUS_OFS, {22'h0, flg});
      host.wr(`UHIRQ_STATUS_OFS, 32'h1 << pos[i]);
      flg[pos[i]] = 1'b0;
      rdx(`UHIRQ_STATUS_OFS, {22'h0, flg});
    end
    @(posedge core_clk);
    clocks_running <= 1'b1;
    repeat (8) @(posedge core_clk);
    flg[6] = 1'b1;
    rdx(`UHIRQ_STATUS_OFS, {22'h0, flg});
    host.wr(`UHIRQ_STATUS_OFS, {22'h0, `UHIRQ_FLAG_MASK});
    flg = '0;
    host.wr(`UHIRQ_ENABLE_OFS, {22'h0, `UHIRQ_FLAG_MASK});
    en = `UHIRQ_FLAG_MASK;
    rdx(`UHIRQ_ENABLE_OFS, {22'h0, en});
    // random events, master enable and clears
    for (int k = 0; k < 24; k++) begin
      m = 6'($random(seed));
      w = $random(seed);
      host.wr(`UHIRQ_MODE_OFS, {31'h0, w[1]});
      mst = w[1];
      w = w & {22'h0, `UHIRQ_FLAG_MASK};
      pulse(m);
      rdx(`UHIRQ_STATUS_OFS, {22'h0, flg});
      host.wr(`UHIRQ_STATUS_OFS, w);
      flg = flg & ~w[9:0];
      rdx(`UHIRQ_STATUS_OFS, {22'h0, flg});
    end
    @(posedge core_clk);
    clocks_running <= 1'b0;
    repeat (4) @(posedge core_clk);
    clocks_running <= 1'b1;
    repeat (8) @(posedge core_clk);
    flg[6] = 1'b1;
    rdx(`UHIRQ_STATUS_OFS, {22'h0, flg});
    // wake window on access while suspended
    host.wr(`UHIRQ_PWRDN_OFS, 32'h00030000);
    rdx(`UHIRQ_PWRDN_OFS, 32'h00030000);
    @(posedge core_clk);
    host_suspended <= 1'b1;
    rdx(`UHIRQ_STATUS_OFS, {22'h0, flg});
    @(posedge core_clk);
    #1 cmp_bit(1'b1, wake_active);
    repeat (12) @(negedge core_clk);
    cmp_bit(1'b0, wake_active);
    // a write in suspend still wakes with the old time, then a zero time cancels
    host.wr(`UHIRQ_PWRDN_OFS, 32'h0);
    @(negedge core_clk);
    cmp_bit(1'b1, wake_active);
    rdx(`UHIRQ_PWRDN_OFS, 32'h0);
    cmp_bit(1'b0, wake_active);
    repeat (3) @(negedge core_clk);
    cmp_bit(1'b0, wake_active);
    @(posedge core_clk);
    host_suspended <= 1'b0;
    summarize();
  end
endmodule : tb_usb_host_irq_status
